// File: rtl/abc_consts.vh
// Purpose: Constants for the block cipher coprocessor
// Assumes: Byte-wide special function register access
// Notes:   Offsets are the printed register addresses
`ifndef ABC_CONSTS_VH
`define ABC_CONSTS_VH
`define ABC_ADDR_INPUT    8'hb1
`define ABC_ADDR_OUTPUT   8'hb2
`define ABC_ADDR_CTRL     8'hb3
`define ABC_CS_GO         0
`define ABC_CS_CMD_LO     1
`define ABC_CS_CMD_HI     2
`define ABC_CS_RDY        3
`define ABC_CS_MODE_LO    4
`define ABC_CS_MODE_HI    6
`define ABC_MODE_CBC      3'h0
`define ABC_MODE_CFB      3'h1
`define ABC_MODE_OFB      3'h2
`define ABC_MODE_CTR      3'h3
`define ABC_MODE_ECB      3'h4
`define ABC_MODE_MAC      3'h5
`define ABC_CMD_ENC       2'h0
`define ABC_CMD_DEC       2'h1
`define ABC_CMD_KEY       2'h2
`define ABC_CMD_IV        2'h3
`define ABC_BLOCK_LAST    4'hf
`define ABC_SEG_LAST_BYTE 4'h3
`define ABC_SEG_LAST      2'h3
`define ABC_ROUNDS        10
`endif

// File: rtl/abc_coprocessor.v
// Purpose: 128-bit block cipher coprocessor with chaining modes and DMA requests
// Assumes: SFR strobes synchronous to clk; sleep inputs high while in deep sleep
// Notes:   The round function is a keyed rotate stand-in for the real cipher rounds
`timescale 1ns/1ps
`default_nettype none
`include "abc_consts.vh"
// Contract
// - Blocks are 128 bits; result must be read before next block loads.
// - Key or IV load start aborts any block operation in progress.
// - Loaded key stays in use until the next key load.
// - Key and IV clear on reset and on deepest sleep entry.
// - Start command raises the DMA input trigger; in CFB, OFB, CTR it rises only once the keystream block is computed.
// - Block completion sets done flag; interrupt only while enable is 1.
// - CFB, OFB, CTR process four 32-bit segments, each loaded then read.
// - Two DMA requests: input bytes needed, output bytes waiting.
// - Mode field: CBC 000, CFB 001, OFB 010, CTR 011, ECB 100, MAC 101.
// - Operation field: 00 encrypt, 01 decrypt, 10 load key, 11 load IV.
// - Go bit self-clears; ready reads 0 while busy, 1 when done, resets 1.
// - All registers return to reset values after the deepest sleep modes.
module abc_coprocessor #(
    parameter ROUNDS = `ABC_ROUNDS
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] sfrAddr,
    input  wire       sfrWrite,
    input  wire       sfrRead,
    input  wire [7:0] sfrWdata,
    output reg  [7:0] sfrRdata,
    input  wire       deepSleepLevelTwo,
    input  wire       deepSleepLevelThree,
    input  wire       cipherIrqEnable,
    input  wire       cipherDoneClear,
    output reg        cipherDoneFlag,
    output reg        irqRequest,
    output reg        dmaFeedRequest,
    output reg        dmaDrainRequest
);
    localparam [4:0] S_IDLE  = 5'h01;
    localparam [4:0] S_LOAD  = 5'h02;
    localparam [4:0] S_FEED  = 5'h04;
    localparam [4:0] S_CORE  = 5'h08;
    localparam [4:0] S_DRAIN = 5'h10;

    function [127:0] encRound;
        input [127:0] s;
        input [127:0] k;
        reg   [127:0] t;
        begin
            t = s ^ k;
            encRound = {t[126:0], t[127]};
        end
    endfunction

    function [127:0] decRound;
        input [127:0] s;
        input [127:0] k;
        begin
            decRound = {s[0], s[127:1]} ^ k;
        end
    endfunction

    function isStream;
        input [2:0] m;
        begin
            isStream = (m == `ABC_MODE_CFB) || (m == `ABC_MODE_OFB) || (m == `ABC_MODE_CTR);
        end
    endfunction

    reg [4:0]   state;
    reg [2:0]   mode;
    reg [1:0]   cmd;
    reg         goBit;
    reg         ready;
    reg [7:0]   inByte;
    reg [127:0] key;
    reg [127:0] iv;
    reg [127:0] inBuf;
    reg [127:0] outBuf;
    reg [127:0] coreState;
    reg [127:0] keyStream;
    reg [31:0]  segBuf;
    reg [3:0]   byteCnt;
    reg [1:0]   segIdx;
    reg [7:0]   roundCnt;
    reg         coreDec;
    reg         opDec;
    reg         loadIsKey;

    wire        sleepClear = deepSleepLevelTwo | deepSleepLevelThree;
    wire        csWrite    = sfrWrite && (sfrAddr == `ABC_ADDR_CTRL);
    wire        diWrite    = sfrWrite && (sfrAddr == `ABC_ADDR_INPUT);
    wire        doRead     = sfrRead && (sfrAddr == `ABC_ADDR_OUTPUT);
    wire [1:0]  wrCmd      = sfrWdata[`ABC_CS_CMD_HI:`ABC_CS_CMD_LO];
    wire [2:0]  wrMode     = sfrWdata[`ABC_CS_MODE_HI:`ABC_CS_MODE_LO];
    wire        startCmd   = csWrite && sfrWdata[`ABC_CS_GO];
    wire        startLoad  = startCmd && wrCmd[1];
    // Block starts are refused until the previous result has been drained
    wire        startBlock = startCmd && !wrCmd[1] && (state == S_IDLE);
    wire        stream     = isStream(mode);
    wire [31:0] segIn      = {segBuf[23:0], sfrWdata};
    wire [31:0] segOut     = segIn ^ keyStream[127:96];
    wire [127:0] blockIn   = {inBuf[119:0], sfrWdata};
    wire        blockDone;
    wire        setDone;

    assign blockDone = (state == S_CORE) && (roundCnt == ROUNDS[7:0]);
    assign setDone   = (blockDone && !stream)
                     || ((state == S_FEED) && stream && diWrite
                         && (byteCnt == `ABC_SEG_LAST_BYTE) && (segIdx == `ABC_SEG_LAST));

    // Done flag: a completion in the clear cycle wins over the clear
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cipherDoneFlag <= 1'b0;
            irqRequest     <= 1'b0;
        end
        else if (sleepClear)
        begin
            cipherDoneFlag <= 1'b0;
            irqRequest     <= 1'b0;
        end
        else
        begin
            cipherDoneFlag <= setDone | (cipherDoneFlag & ~cipherDoneClear);
            irqRequest     <= (setDone | (cipherDoneFlag & ~cipherDoneClear)) & cipherIrqEnable;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfrRdata <= 8'h00;
        else if (sleepClear)
            sfrRdata <= 8'h00;
        else
        begin
            case (sfrAddr)
                `ABC_ADDR_INPUT:  sfrRdata <= inByte;
                `ABC_ADDR_OUTPUT: sfrRdata <= outBuf[127:120];
                `ABC_ADDR_CTRL:   sfrRdata <= {1'b0, mode, ready, cmd, goBit};
                default:          sfrRdata <= 8'h00;
            endcase
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE; mode <= 3'h0; cmd <= 2'h0; goBit <= 1'b0;
            ready <= 1'b1; inByte <= 8'h00; key <= 128'h0; iv <= 128'h0;
            inBuf <= 128'h0; outBuf <= 128'h0; coreState <= 128'h0; keyStream <= 128'h0;
            segBuf <= 32'h0; byteCnt <= 4'h0; segIdx <= 2'h0; roundCnt <= 8'h00;
            coreDec <= 1'b0; opDec <= 1'b0; loadIsKey <= 1'b0;
            dmaFeedRequest <= 1'b0; dmaDrainRequest <= 1'b0;
        end
        else if (sleepClear)
        begin
            // Deep sleep wipes secrets and returns every register to reset
            state <= S_IDLE; mode <= 3'h0; cmd <= 2'h0; goBit <= 1'b0;
            ready <= 1'b1; inByte <= 8'h00; key <= 128'h0; iv <= 128'h0;
            inBuf <= 128'h0; outBuf <= 128'h0; coreState <= 128'h0; keyStream <= 128'h0;
            segBuf <= 32'h0; byteCnt <= 4'h0; segIdx <= 2'h0; roundCnt <= 8'h00;
            coreDec <= 1'b0; opDec <= 1'b0; loadIsKey <= 1'b0;
            dmaFeedRequest <= 1'b0; dmaDrainRequest <= 1'b0;
        end
        else
        begin
            goBit <= startCmd;
            if (csWrite)
            begin
                mode <= wrMode;
                cmd  <= wrCmd;
            end
            if (diWrite)
                inByte <= sfrWdata;
            if (startLoad)
            begin
                // Abort whatever block work is in flight
                state           <= S_LOAD;
                loadIsKey       <= (wrCmd == `ABC_CMD_KEY);
                byteCnt         <= 4'h0;
                ready           <= 1'b0;
                dmaFeedRequest  <= 1'b1;
                dmaDrainRequest <= 1'b0;
            end
            else if (startBlock)
            begin
                opDec   <= (wrCmd == `ABC_CMD_DEC);
                ready   <= 1'b0;
                byteCnt <= 4'h0;
                segIdx  <= 2'h0;
                if (isStream(wrMode))
                begin
                    // Keystream is made from the chaining value before any data arrives
                    state     <= S_CORE;
                    coreState <= iv;
                    coreDec   <= 1'b0;
                    roundCnt  <= 8'h00;
                end
                else
                begin
                    state          <= S_FEED;
                    dmaFeedRequest <= 1'b1;
                end
            end
            else
            begin
                case (state)
                    S_IDLE: ;
                    S_LOAD:
                        if (diWrite)
                        begin
                            inBuf   <= blockIn;
                            byteCnt <= byteCnt + 4'h1;
                            if (byteCnt == `ABC_BLOCK_LAST)
                            begin
                                if (loadIsKey)
                                    key <= blockIn;
                                else
                                    iv <= blockIn;
                                state          <= S_IDLE;
                                ready          <= 1'b1;
                                dmaFeedRequest <= 1'b0;
                            end
                        end
                    S_FEED:
                        if (diWrite && stream)
                        begin
                            segBuf  <= segIn;
                            byteCnt <= byteCnt + 4'h1;
                            if (byteCnt == `ABC_SEG_LAST_BYTE)
                            begin
                                outBuf    <= {segOut, 96'h0};
                                keyStream <= {keyStream[95:0], 32'h0};
                                if (mode == `ABC_MODE_CFB)
                                    iv <= {iv[95:0], (opDec ? segIn : segOut)};
                                if (segIdx == `ABC_SEG_LAST)
                                    ready <= 1'b1;
                                byteCnt         <= 4'h0;
                                state           <= S_DRAIN;
                                dmaFeedRequest  <= 1'b0;
                                dmaDrainRequest <= 1'b1;
                            end
                        end
                        else if (diWrite)
                        begin
                            inBuf   <= blockIn;
                            byteCnt <= byteCnt + 4'h1;
                            if (byteCnt == `ABC_BLOCK_LAST)
                            begin
                                state          <= S_CORE;
                                dmaFeedRequest <= 1'b0;
                                roundCnt       <= 8'h00;
                                // MAC chaining always runs the forward direction
                                coreDec        <= opDec && (mode != `ABC_MODE_MAC);
                                if ((mode == `ABC_MODE_ECB) || (opDec && (mode == `ABC_MODE_CBC)))
                                    coreState <= blockIn;
                                else
                                    coreState <= blockIn ^ iv;
                            end
                        end
                    S_CORE:
                        if (!blockDone)
                        begin
                            roundCnt  <= roundCnt + 8'h01;
                            coreState <= coreDec ? decRound(coreState, key) : encRound(coreState, key);
                        end
                        else if (stream)
                        begin
                            keyStream <= coreState;
                            if (mode == `ABC_MODE_OFB)
                                iv <= coreState;
                            else if (mode == `ABC_MODE_CTR)
                                iv <= iv + 128'h1;
                            state          <= S_FEED;
                            dmaFeedRequest <= 1'b1;
                        end
                        else
                        begin
                            ready   <= 1'b1;
                            byteCnt <= 4'h0;
                            if (mode == `ABC_MODE_CBC && opDec)
                            begin
                                outBuf <= coreState ^ iv;
                                iv     <= inBuf;
                            end
                            else
                            begin
                                outBuf <= coreState;
                                if (mode != `ABC_MODE_ECB)
                                    iv <= coreState;
                            end
                            // Intermediate MAC blocks are chained only, nothing to read
                            if (mode == `ABC_MODE_MAC)
                                state <= S_IDLE;
                            else
                            begin
                                state           <= S_DRAIN;
                                dmaDrainRequest <= 1'b1;
                            end
                        end
                    S_DRAIN:
                        if (doRead)
                        begin
                            outBuf  <= {outBuf[119:0], 8'h00};
                            byteCnt <= byteCnt + 4'h1;
                            if (stream && byteCnt == `ABC_SEG_LAST_BYTE)
                            begin
                                byteCnt         <= 4'h0;
                                segIdx          <= segIdx + 2'h1;
                                dmaDrainRequest <= 1'b0;
                                if (segIdx == `ABC_SEG_LAST)
                                    state <= S_IDLE;
                                else
                                begin
                                    state          <= S_FEED;
                                    dmaFeedRequest <= 1'b1;
                                end
                            end
                            else if (!stream && byteCnt == `ABC_BLOCK_LAST)
                            begin
                                state           <= S_IDLE;
                                dmaDrainRequest <= 1'b0;
                            end
                        end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end
endmodule // abc_coprocessor
`default_nettype wire

// File: verification/abc_coprocessor_assertions.sv
// Purpose: Port-level checks for the cipher coprocessor
// Assumes: Only the top module ports are visible
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module abc_coprocessor_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic       deepSleepLevelTwo,
    input wire logic       deepSleepLevelThree,
    input wire logic       cipherIrqEnable,
    input wire logic       cipherDoneClear,
    input wire logic       cipherDoneFlag,
    input wire logic       irqRequest,
    input wire logic       dmaFeedRequest,
    input wire logic       dmaDrainRequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic sleeping = deepSleepLevelTwo | deepSleepLevelThree;
    irq_enable_gate_a: assert property ($past(!cipherIrqEnable) |-> !irqRequest)
        else $error("interrupt request without enable");
    irq_raise_a: assert property (cipherDoneFlag && cipherIrqEnable && $past(cipherIrqEnable) && !sleeping
        |-> ##[0:1] irqRequest) else $error("interrupt request missing");
    key_start_feed_a: assert property (sfrWrite && sfrAddr == 8'hb3 && sfrWdata[0] && sfrWdata[2]
        && !sleeping |=> dmaFeedRequest) else $error("load start raised no feed request");
    req_exclusive_a: assert property (!(dmaFeedRequest && dmaDrainRequest))
        else $error("feed and drain requests together");
    flag_sticky_a: assert property (cipherDoneFlag && !cipherDoneClear && !sleeping |=> cipherDoneFlag)
        else $error("done flag dropped by itself");
    sleep_clear_a: assert property (sleeping |=> !cipherDoneFlag && !dmaFeedRequest && !dmaDrainRequest)
        else $error("deep sleep left state behind");
    ctrl_bit_seven_a: assert property (sfrAddr == 8'hb3 |=> !sfrRdata[7])
        else $error("unused control bit reads one");
    unmapped_zero_a: assert property (!(sfrAddr inside {8'hb1, 8'hb2, 8'hb3}) |=> sfrRdata == 8'h00)
        else $error("unmapped address read nonzero");
endmodule // abc_coprocessor_assertions
bind abc_coprocessor abc_coprocessor_assertions abc_coprocessor_assertions_inst (.clk(clk), .rst_n(rst_n),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .deepSleepLevelTwo(deepSleepLevelTwo), .deepSleepLevelThree(deepSleepLevelThree),
    .cipherIrqEnable(cipherIrqEnable), .cipherDoneClear(cipherDoneClear), .cipherDoneFlag(cipherDoneFlag),
    .irqRequest(irqRequest), .dmaFeedRequest(dmaFeedRequest), .dmaDrainRequest(dmaDrainRequest));
`default_nettype wire

// File: verification/abc_host_model.sv
// Purpose: Firmware and DMA channels driving the register bus
// Assumes: Tasks are entered just after a rising edge
// Notes:   DMA moves bytes only while the matching request is high
`timescale 1ns/1ps
`default_nettype none
module abc_host_model (
    input  wire logic       clk,
    input  wire logic       dmaFeedRequest,
    input  wire logic       dmaDrainRequest,
    input  wire logic [7:0] sfrRdata,
    output var  logic [7:0] sfrAddr,
    output var  logic       sfrWrite,
    output var  logic       sfrRead,
    output var  logic [7:0] sfrWdata
);
    int stalls = 0;
    initial
    begin
        sfrAddr = 8'h00;
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
        sfrWdata = 8'h00;
    end
    // One access per call, held across one sampling edge, then one idle edge so that
    // back-to-back calls never lower and raise a strobe in the same time step
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        sfrAddr = a;
        sfrWrite = wr;
        sfrRead = !wr;
        sfrWdata = d;
        @(posedge clk);
        #1;
        q = sfrRdata;
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
        // Released data must not keep looking valid
        sfrWdata = ~d;
        @(posedge clk);
        #1;
    endtask
    // Start a command, then let the channels serve feed and drain until all bytes moved
    task automatic xfer(input logic [1:0] cmd, input logic [2:0] mode, input logic [127:0] din,
                        input int nout, output logic [127:0] dout, output int run);
        int ni;
        int no;
        int n;
        int cur;
        logic [7:0] q;
        ni = 0;
        no = 0;
        cur = 0;
        run = 0;
        dout = '0;
        acc(1'b1, 8'hb3, {1'b0, mode, 1'b0, cmd, 1'b1}, q);
        for (n = 0; n < 400 && (ni < 16 || no < nout); n++)
            if (dmaFeedRequest && ni < 16)
            begin
                acc(1'b1, 8'hb1, din[127 - 8 * ni -: 8], q);
                ni++;
                cur++;
            end
            else if (dmaDrainRequest && no < nout)
            begin
                acc(1'b0, 8'hb2, 8'h00, q);
                dout[127 - 8 * no -: 8] = q;
                no++;
                run = cur > run ? cur : run;
                cur = 0;
            end
            else
            begin
                @(posedge clk);
                #1;
            end
        if (ni < 16 || no < nout)
            stalls++;
    endtask
endmodule // abc_host_model
`default_nettype wire

// File: verification/aes_block_coprocessor_tb_top.sv
// Purpose: Self-checking bench for the cipher coprocessor
// Assumes: Round count shortened to 2 to keep runs short
// Notes:   Expected data comes from round trips and reference runs on the design, not a cipher model
`timescale 1ns/1ps
`default_nettype none
`define ABC_CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module aes_block_coprocessor_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, sleepTwo = 1'b0, sleepThree = 1'b0, irqEn = 1'b0, doneClr = 1'b0;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata;
    logic sfrWrite, sfrRead, doneFlag, irqReq, feedReq, drainReq;
    logic [31:0] seed = 32'h0000c5a5;
    int failures = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    abc_coprocessor #(.ROUNDS(2)) abc_coprocessor_inst (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .deepSleepLevelTwo(sleepTwo), .deepSleepLevelThree(sleepThree), .cipherIrqEnable(irqEn),
        .cipherDoneClear(doneClr), .cipherDoneFlag(doneFlag), .irqRequest(irqReq),
        .dmaFeedRequest(feedReq), .dmaDrainRequest(drainReq));
    abc_host_model abc_host_model_inst (.clk(clk), .dmaFeedRequest(feedReq), .dmaDrainRequest(drainReq),
        .sfrRdata(sfrRdata), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [127:0] rnd();
        return {xs(), xs(), xs(), xs()};
    endfunction
    // Stream modes move four bytes per segment before draining
    function automatic int burst(input int mode);
        return (mode >= 1 && mode <= 3) ? 4 : 16;
    endfunction
    task automatic report_and_stop();
        failures += abc_host_model_inst.stalls;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (50000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial
    begin
        logic [127:0] key, iv, p, c, r, x, y;
        logic [31:0] t;
        logic [7:0] q;
        int run, m, s, n;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        abc_host_model_inst.acc(1'b0, 8'hb3, 8'h00, q);
        `ABC_CHK("control reset", 8'h08, q)
        abc_host_model_inst.acc(1'b0, 8'hb1, 8'h00, q);
        `ABC_CHK("input reset", 8'h00, q)
        abc_host_model_inst.acc(1'b1, 8'hb2, 8'h5a, q);
        abc_host_model_inst.acc(1'b0, 8'h00, 8'h00, q);
        `ABC_CHK("unmapped read", 8'h00, q)
        key = rnd();
        abc_host_model_inst.xfer(2'h2, 3'h0, key, 0, r, run);
        for (m = 0; m < 5; m++)
        begin
            t = xs();
            irqEn = t[0];
            p = rnd();
            iv = rnd();
            abc_host_model_inst.xfer(2'h3, m[2:0], iv, 0, r, run);
            // Clear first so that the flag seen after the block is this block's own
            doneClr = 1'b1;
            @(posedge clk);
            #1 doneClr = 1'b0;
            `ABC_CHK("flag cleared", 1'b0, doneFlag)
            abc_host_model_inst.xfer(2'h0, m[2:0], p, 16, c, run);
            `ABC_CHK("done flag", 1'b1, doneFlag)
            `ABC_CHK("irq request", irqEn, irqReq)
            `ABC_CHK("bytes per burst", burst(m), run)
            `ABC_CHK("cipher changed data", 1'b1, c !== p)
            abc_host_model_inst.xfer(2'h3, m[2:0], iv, 0, r, run);
            abc_host_model_inst.xfer(2'h1, m[2:0], c, 16, r, run);
            `ABC_CHK("round trip", p, r)
        end
        // Reference: the same two blocks chained in plain CBC from the same IV
        x = rnd();
        abc_host_model_inst.xfer(2'h3, 3'h0, iv, 0, r, run);
        abc_host_model_inst.xfer(2'h0, 3'h0, p, 16, c, run);
        abc_host_model_inst.xfer(2'h0, 3'h0, x, 16, y, run);
        abc_host_model_inst.xfer(2'h3, 3'h5, iv, 0, r, run);
        doneClr = 1'b1;
        @(posedge clk);
        #1 doneClr = 1'b0;
        abc_host_model_inst.xfer(2'h0, 3'h5, p, 0, r, run);
        // The feed ends before the core does; completion is the cue for the next start
        for (n = 0; n < 20 && !doneFlag; n++)
        begin
            @(posedge clk);
            #1;
        end
        `ABC_CHK("mac done", 1'b1, doneFlag)
        `ABC_CHK("mac no drain", 1'b0, drainReq)
        abc_host_model_inst.xfer(2'h0, 3'h0, x, 16, r, run);
        `ABC_CHK("mac value", y, r)
        // Key load in mid-block must abort the pending block
        abc_host_model_inst.acc(1'b1, 8'hb3, 8'h41, q);
        repeat (5) abc_host_model_inst.acc(1'b1, 8'hb1, 8'(xs()), q);
        abc_host_model_inst.xfer(2'h2, 3'h4, key, 0, r, run);
        abc_host_model_inst.acc(1'b0, 8'hb3, 8'h00, q);
        `ABC_CHK("abort status", 8'h4c, q)
        `ABC_CHK("abort no drain", 1'b0, drainReq)
        abc_host_model_inst.xfer(2'h0, 3'h4, p, 16, c, run);
        abc_host_model_inst.xfer(2'h1, 3'h4, c, 16, r, run);
        `ABC_CHK("after abort", p, r)
        for (s = 0; s < 2; s++)
        begin
            abc_host_model_inst.xfer(2'h2, 3'h4, rnd(), 0, r, run);
            sleepTwo = (s == 0);
            sleepThree = (s == 1);
            @(posedge clk);
            #1 sleepTwo = 1'b0;
            sleepThree = 1'b0;
            abc_host_model_inst.acc(1'b0, 8'hb3, 8'h00, q);
            `ABC_CHK("sleep control", 8'h08, q)
            abc_host_model_inst.xfer(2'h0, 3'h4, p, 16, x, run);
            abc_host_model_inst.xfer(2'h2, 3'h4, 128'h0, 0, r, run);
            abc_host_model_inst.xfer(2'h0, 3'h4, p, 16, y, run);
            `ABC_CHK("key cleared", y, x)
        end
        report_and_stop();
    end
endmodule // aes_block_coprocessor_tb_top
`default_nettype wire
